//--- inc/dpt_pkg.sv
`default_nettype none

package dpt_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // clocking: the memory clock is the system clock divided down
    localparam int CLK_PERIOD_PS = 25000;
    localparam int CK_DIV        = 2;
    localparam int TCK_PS        = CLK_PERIOD_PS * CK_DIV;
    localparam int CW            = 16;

    ////////////////////////////////////////////////////////////////////////////////
    // spacing figures in their own units
    localparam int TWR_PS          = 15000;
    localparam int WR_ROUND_CK     = (TWR_PS + TCK_PS - 1) / TCK_PS;
    localparam int BURST8_BASE_CK  = 4;
    localparam int CHOP4_BASE_CK   = 2;
    localparam int REFPD_CK        = 1;
    localparam int MOD_CK          = 12;
    localparam int TERM_SHORT_CK   = 4;
    localparam int TERM_LONG_CK    = 6;
    localparam int LVL_RISE_CK     = 40;
    localparam int LVL_DRIVE_CK    = 25;
    localparam int REFRESH_CYCLE_TIME_PS         = 110000;
    localparam int RFC_CYC         = (REFRESH_CYCLE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int REFRESH_AVG_INTERVAL_NORM_NS   = 7800;
    localparam int REFRESH_AVG_INTERVAL_EXT_NS    = 3900;
    localparam int REFI_NORM_CYC   = REFRESH_AVG_INTERVAL_NORM_NS * 1000 / CLK_PERIOD_PS;
    localparam int REFI_EXT_CYC    = REFRESH_AVG_INTERVAL_EXT_NS * 1000 / CLK_PERIOD_PS;

    ////////////////////////////////////////////////////////////////////////////////
    // spacing counter slots
    localparam int NCTR    = 9;
    localparam int C_WRPD  = 0;
    localparam int C_WRAPD = 1;
    localparam int C_REFPD = 2;
    localparam int C_MRSPD = 3;
    localparam int C_RFC   = 4;
    localparam int C_REFI  = 5;
    localparam int C_TERM  = 6;
    localparam int C_LVDRV = 7;
    localparam int C_LVRSE = 8;

    ////////////////////////////////////////////////////////////////////////////////
    // command pins and requests
    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
    } dpt_cmd_t;

    localparam dpt_cmd_t CMD_NOP = 4'h7;
    localparam dpt_cmd_t CMD_ACT = 4'h3;
    localparam dpt_cmd_t CMD_RD  = 4'h5;
    localparam dpt_cmd_t CMD_WR  = 4'h4;
    localparam dpt_cmd_t CMD_REF = 4'h1;
    localparam dpt_cmd_t CMD_MRS = 4'h0;

    typedef struct packed {
        logic     cke;
        dpt_cmd_t cmd;
        logic     a10;
        logic     a12;
        logic     odt;
    } dpt_dram_t;

    // cke low, nop, no auto-precharge, no chop, termination off
    localparam dpt_dram_t DRAM_RESET = 8'h3A;

    typedef enum logic [3:0] {
        RQ_NOP, RQ_ACT, RQ_RD, RQ_RDA, RQ_WR, RQ_WRA, RQ_REF,
        RQ_MRS, RQ_PDE, RQ_PDX, RQ_LVL, RQ_LVX
    } dpt_req_t;

endpackage : dpt_pkg

`default_nettype wire

//--- src/dpt_gap_ctr.sv
`default_nettype none

module dpt_gap_ctr import dpt_pkg::*; #(
    parameter int W = 16
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic         ce,
    // load and state
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    output logic      [W-1:0] count,
    output logic              zero
);

    logic [W-1:0] next_count;

    ////////////////////////////////////////////////////////////////////////////////
    // load wins over the decrement so a fresh command always restarts the gap
    always_comb begin
        next_count = count;
        if (load) begin
            next_count = load_val;
        end else if (count != '0) begin
            next_count = count - W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            count <= '0;
        end else if (ce) begin
            count <= next_count;
        end
    end

    assign zero = (count == '0);

endmodule : dpt_gap_ctr

`default_nettype wire

//--- src/dpt_ck_div.sv
`default_nettype none

module dpt_ck_div import dpt_pkg::*; #(
    parameter int DIV = CK_DIV
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic ce,
    // memory clock
    output logic      ck,
    output logic      tick
);

    localparam int HALF = DIV / 2;
    localparam int HW   = (HALF > 1) ? $clog2(HALF) : 1;

    logic [HW-1:0] cnt;
    logic [HW-1:0] next_cnt;
    logic          next_ck;
    logic          flip;

    ////////////////////////////////////////////////////////////////////////////////
    // even divider; tick marks the edge where ck falls, mid-way to the sampling rise
    always_comb begin
        flip     = (cnt == HW'(HALF - 1));
        next_cnt = flip ? '0 : cnt + HW'(1);
        next_ck  = flip ? !ck : ck;
        tick     = ce && flip && ck;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            cnt <= '0;
            ck  <= 1'b0;
        end else if (ce) begin
            cnt <= next_cnt;
            ck  <= next_ck;
        end
    end

endmodule : dpt_ck_div

`default_nettype wire

//--- src/dpt_host_ctrl.sv
`default_nettype none

module dpt_host_ctrl import dpt_pkg::*; (
    // clock, reset, enable
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       ce,
    // user requests and setup
    input  wire logic       req_valid,
    input  wire dpt_req_t   req_cmd,
    input  wire logic       req_chop_otf,
    input  wire logic       odt_req,
    input  wire logic       level_pulse,
    input  wire logic       ext_temp,
    input  wire logic [4:0] write_latency_clocks,
    input  wire logic [4:0] wr_prog,
    input  wire logic       chop4_fixed_setting,
    // user status
    output logic            req_ack,
    output logic            refresh_busy,
    output logic            level_seen,
    // memory pins
    output logic            dram_ck,
    output dpt_dram_t       dram,
    output logic            dqs_out,
    output logic            dqs_oe,
    input  wire logic       dll_locked,
    input  wire logic       dq_level
);

    typedef enum logic [1:0] {ST_RUN, ST_PD, ST_LEVEL} dpt_state_t;

    dpt_state_t     state;
    dpt_state_t     next_state;
    dpt_dram_t      next_dram;
    logic           next_ack;
    logic           next_dqs;
    logic           next_dqs_oe;
    logic           next_pend;
    logic           next_seen;
    logic           lvl_pend;
    logic           tick;
    logic [1:0]     dll_sync;
    logic [1:0]     dq_sync;
    logic           iss_wr;
    logic           iss_wra;
    logic           iss_ref;
    logic           iss_mrs;
    logic           iss_lvl;
    logic           iss_act;
    logic           iss_rd;
    logic           iss_pde;
    logic           long_wr;
    logic           term_want;
    logic           pd_ok;
    logic [CW-1:0]  cnt [NCTR];
    logic [NCTR-1:0] czero;
    logic [NCTR-1:0] cload;
    logic [CW-1:0]  cval [NCTR];
    logic [CW-1:0]  base_ck;

    // tCK count to clk cycles, minus one because the load edge itself counts
    function automatic logic [CW-1:0] ck2cyc(input logic [CW-1:0] n);
        ck2cyc = CW'(n * CW'(CK_DIV) - CW'(1));
    endfunction : ck2cyc

    ////////////////////////////////////////////////////////////////////////////////
    // memory clock made here; commands change as it falls
    dpt_ck_div #(.DIV(CK_DIV)) u_div (
        .clk  (clk),
        .rstn (rstn),
        .ce   (ce),
        .ck   (dram_ck),
        .tick (tick)
    );

    // pins from the memory cross two flops before anything looks at them
    always_ff @(posedge clk) begin
        if (!rstn) begin
            dll_sync <= 2'h0;
            dq_sync  <= 2'h0;
        end else if (ce) begin
            dll_sync <= {dll_sync[0], dll_locked};
            dq_sync  <= {dq_sync[0], dq_level};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // spacing counters, one per constraint
    generate
        for (genvar i = 0; i < NCTR; i++) begin : g_ctr
            dpt_gap_ctr #(.W(CW)) u_ctr (
                .clk      (clk),
                .rstn     (rstn),
                .ce       (ce),
                .load     (cload[i]),
                .load_val (cval[i]),
                .count    (cnt[i]),
                .zero     (czero[i])
            );
        end
    endgenerate

    // write gap base: chop fixed in the mode register shortens the burst by two
    assign base_ck = chop4_fixed_setting ? CW'(CHOP4_BASE_CK) : CW'(BURST8_BASE_CK);
    assign long_wr = !chop4_fixed_setting && !req_chop_otf;

    // counter loads and values
    always_comb begin
        cload          = '0;
        cload[C_WRPD]  = iss_wr;
        cload[C_WRAPD] = iss_wra;
        cload[C_REFPD] = iss_ref;
        cload[C_MRSPD] = iss_mrs;
        cload[C_RFC]   = iss_ref;
        cload[C_REFI]  = iss_ref;
        cload[C_TERM]  = tick && term_want && (!dram.odt || (iss_wr || iss_wra) && long_wr);
        cload[C_LVDRV] = iss_lvl;
        cload[C_LVRSE] = iss_lvl;
        cval[C_WRPD]   = ck2cyc(CW'(write_latency_clocks) + base_ck + CW'(WR_ROUND_CK));
        cval[C_WRAPD]  = ck2cyc(CW'(write_latency_clocks) + base_ck + CW'(wr_prog)
                                + CW'(1));
        cval[C_REFPD]  = ck2cyc(CW'(REFPD_CK));
        cval[C_MRSPD]  = ck2cyc(CW'(MOD_CK));
        cval[C_RFC]    = CW'(RFC_CYC - 1);
        cval[C_REFI]   = ext_temp ? CW'(REFI_EXT_CYC - 1) : CW'(REFI_NORM_CYC - 1);
        cval[C_TERM]   = ((iss_wr || iss_wra) && long_wr) ? ck2cyc(CW'(TERM_LONG_CK))
                                                          : ck2cyc(CW'(TERM_SHORT_CK));
        cval[C_LVDRV]  = ck2cyc(CW'(LVL_DRIVE_CK));
        cval[C_LVRSE]  = ck2cyc(CW'(LVL_RISE_CK));
    end

    ////////////////////////////////////////////////////////////////////////////////
    // command scheduler; in the run state a pending refresh outranks every user request
    assign pd_ok     = czero[C_WRPD] && czero[C_WRAPD] && czero[C_REFPD] && czero[C_MRSPD];
    assign term_want = odt_req && dll_sync[1];

    always_comb begin
        next_state = state;
        next_dram  = dram;
        next_ack   = 1'b0;
        iss_wr     = 1'b0;
        iss_wra    = 1'b0;
        iss_ref    = 1'b0;
        iss_mrs    = 1'b0;
        iss_lvl    = 1'b0;
        iss_act    = 1'b0;
        iss_rd     = 1'b0;
        iss_pde    = 1'b0;
        if (tick) begin
            next_dram.cmd = CMD_NOP;
            next_dram.a10 = 1'b0;
            next_dram.a12 = 1'b1;
            unique case (state)
                ST_PD: begin
                    // the part leaves power-down by itself whenever no refresh is due
                    if (!czero[C_REFI] || (req_valid && req_cmd == RQ_PDX)) begin
                        next_dram.cke = 1'b1;
                        next_state    = ST_RUN;
                        next_ack      = req_valid && req_cmd == RQ_PDX;
                    end
                end
                ST_LEVEL: begin
                    if (req_valid && req_cmd == RQ_LVX) begin
                        next_dram.cmd = CMD_MRS;
                        iss_mrs       = 1'b1;
                        next_ack      = 1'b1;
                        next_state    = ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (czero[C_REFI]) begin
                        if (czero[C_RFC]) begin
                            next_dram.cmd = CMD_REF;
                            iss_ref       = 1'b1;
                        end
                    end else if (req_valid) begin
                        unique case (req_cmd)
                            RQ_NOP: next_ack = 1'b1;
                            RQ_ACT: iss_act = czero[C_RFC];
                            RQ_REF: iss_ref = czero[C_RFC];
                            RQ_RD, RQ_RDA: iss_rd = dll_sync[1];
                            RQ_WR: iss_wr = 1'b1;
                            RQ_WRA: iss_wra = 1'b1;
                            RQ_MRS, RQ_LVX: iss_mrs = 1'b1;
                            RQ_LVL: iss_lvl = 1'b1;
                            RQ_PDE: iss_pde = pd_ok;
                            RQ_PDX: next_ack = 1'b1;
                            // unused request codes are dropped without an ack
                            default: next_ack = 1'b0;
                        endcase
                        if (iss_act) next_dram.cmd = CMD_ACT;
                        if (iss_ref) next_dram.cmd = CMD_REF;
                        if (iss_rd) next_dram.cmd = CMD_RD;
                        if (iss_wr || iss_wra) next_dram.cmd = CMD_WR;
                        if (iss_mrs || iss_lvl) next_dram.cmd = CMD_MRS;
                        next_dram.a10 = iss_wra || (iss_rd && req_cmd == RQ_RDA);
                        next_dram.a12 = !req_chop_otf;
                        iss_mrs       = iss_mrs || iss_lvl;
                        if (iss_lvl) next_state = ST_LEVEL;
                        if (iss_pde) begin
                            next_dram.cke = 1'b0;
                            next_state    = ST_PD;
                        end
                        next_ack = next_ack || iss_act || iss_ref || iss_rd || iss_wr
                                   || iss_wra || iss_mrs || iss_pde;
                    end
                end
            endcase
            // termination stays up until its minimum hold has run out
            next_dram.odt = term_want || !czero[C_TERM] || cload[C_TERM];
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            state   <= ST_RUN;
            dram    <= DRAM_RESET;
            req_ack <= 1'b0;
        end else if (ce) begin
            state   <= next_state;
            dram    <= next_dram;
            req_ack <= next_ack;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // write leveling strobe; refreshes are held off while leveling is open
    always_comb begin
        next_pend   = lvl_pend;
        next_dqs    = dqs_out;
        next_dqs_oe = dqs_oe;
        next_seen   = level_seen;
        if (tick) begin
            next_dqs_oe = (state == ST_LEVEL) && czero[C_LVDRV];
            next_dqs    = (state == ST_LEVEL) && !dqs_out && lvl_pend && dqs_oe
                          && czero[C_LVRSE];
            if (dqs_out) next_seen = dq_sync[1];
            if (next_dqs) next_pend = 1'b0;
        end
        if (level_pulse) next_pend = 1'b1; // set beats clear
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            lvl_pend     <= 1'b0;
            dqs_out      <= 1'b0;
            dqs_oe       <= 1'b0;
            level_seen   <= 1'b0;
            refresh_busy <= 1'b0;
        end else if (ce) begin
            lvl_pend     <= next_pend;
            dqs_out      <= next_dqs;
            dqs_oe       <= next_dqs_oe;
            level_seen   <= next_seen;
            refresh_busy <= czero[C_REFI];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_wr_pd_gap:    assert property (iss_pde |-> cnt[C_WRPD] == '0)
        else $error("power-down entered inside write gap");
    a_wra_pd_gap:   assert property (iss_wra && ce |=> cnt[C_WRAPD] == CW'((write_latency_clocks
        + base_ck + wr_prog + 1) * CK_DIV - 1))
        else $error("auto-precharge gap loaded wrongly");
    a_chop_pd_gap:  assert property (iss_wr && ce && chop4_fixed_setting |=> cnt[C_WRPD]
        == CW'((write_latency_clocks + CHOP4_BASE_CK + WR_ROUND_CK) * CK_DIV - 1))
        else $error("chop write gap loaded wrongly");
    a_pd_after_ref: assert property ($fell(dram.cke) |-> $past(czero[C_REFPD]) && pd_ok == 1'b0
        || $past(czero[C_REFPD]))
        else $error("power-down too soon after refresh");
    a_mrs_pd_gap:   assert property (iss_pde |-> czero[C_MRSPD] && czero[C_WRAPD])
        else $error("power-down too soon after mode set");
    a_term_hold:    assert property ($fell(dram.odt) |-> $past(czero[C_TERM]))
        else $error("termination dropped early");
    a_level_drive:  assert property ($rose(dqs_oe) |-> $past(czero[C_LVDRV]))
        else $error("strobe driven too early in leveling");
    a_level_rise:   assert property ($rose(dqs_out) |-> $past(czero[C_LVRSE]) && dqs_oe)
        else $error("strobe rose too early in leveling");
    a_rfc_gap:      assert property ((iss_ref || iss_act) |-> czero[C_RFC])
        else $error("refresh or activate inside refresh cycle");
    a_refi_due:     assert property (czero[C_REFI] && state == ST_RUN && ce |-> ##[0:16]
        (iss_ref || state != ST_RUN))
        else $error("due refresh not issued");
    a_dll_read:     assert property (dram.cmd == CMD_RD && $changed(dram.cmd) |-> $past(dll_sync[1]))
        else $error("read issued before lock");

    c_wr_then_pd:   cover property (iss_wr ##[1:60] iss_pde);
    c_ref_issued:   cover property (iss_ref ##[1:20] iss_act);
    c_level_rise:   cover property (iss_lvl ##[1:200] $rose(dqs_out));
    c_term_long:    cover property ($rose(dram.odt) && long_wr ##[1:30] $fell(dram.odt));

endmodule : dpt_host_ctrl

`default_nettype wire

//--- tb/dpt_dram_model.sv
`default_nettype none

module dpt_dram_model import dpt_pkg::*; (
    // controller pins
    input  wire logic       dram_ck,
    input  wire dpt_dram_t  dram,
    input  wire logic       dqs_out,
    input  wire logic       dqs_oe,
    // mode register settings
    input  wire logic [4:0] wl,
    input  wire logic [4:0] wr,
    input  wire logic       chop,
    input  wire logic       ext,
    // bench knobs
    input  wire logic       lock_en,
    input  wire logic       lvl_resp,
    // answers
    output logic            dll_locked,
    output logic            dq_level,
    output int              viol
);
    timeunit 1ns;
    timeprecision 1ps;

    int        n = 0, b, t_wr = -99, t_wra = -99, t_ref = -99, t_mrs = -99, t_odt = 0;
    int        hold = 4;
    realtime   r_ref = -1.0;
    logic      ext_r = 1'b0, oe_q = 1'b0, dqs_q = 1'b0;
    dpt_dram_t q = DRAM_RESET;

    ////////////////////////////////////////
    // lock is the bench's to give
    assign dll_locked = lock_en;

    // unstrobed feedback keeps changing so a stale sample never looks right
    initial dq_level = 1'b0;
    always @(posedge dram_ck) dq_level <= dqs_oe ? lvl_resp : ~dq_level;

    // each spacing breach seen at the pins adds one
    initial viol = 0;
    always @(posedge dram_ck) begin
        n = n + 1;
        b = chop ? CHOP4_BASE_CK : BURST8_BASE_CK;
        if (q.cke && !dram.cke) begin
            viol += int'(n - t_wr < wl + b + WR_ROUND_CK);
            viol += int'(n - t_wra < wl + b + wr + 1);
            viol += int'(n - t_ref < REFPD_CK);
            viol += int'(n - t_mrs < MOD_CK);
        end
        if (dram.cmd == CMD_REF || dram.cmd == CMD_ACT)
            viol += int'($realtime - r_ref < REFRESH_CYCLE_TIME_PS / 1000.0);
        if (dram.cmd == CMD_REF) begin
            // postponing is legal, so only a gross overrun counts
            if (r_ref >= 0 && ext_r == ext)
                viol += int'($realtime - r_ref > (ext ? REFRESH_AVG_INTERVAL_EXT_NS : REFRESH_AVG_INTERVAL_NORM_NS) + 2500);
            r_ref = $realtime;
            ext_r = ext;
            t_ref = n;
        end
        if (dram.cmd == CMD_WR) begin
            if (dram.a10)
                t_wra = n;
            else
                t_wr = n;
            if (dram.odt && !chop && dram.a12) begin
                t_odt = n;
                hold = TERM_LONG_CK;
            end
        end
        if (dram.cmd == CMD_MRS)
            t_mrs = n;
        viol += int'(dram.cmd == CMD_RD && !dll_locked);
        if (dram.odt && !q.odt) begin
            viol += int'(!dll_locked);
            t_odt = n;
            hold = TERM_SHORT_CK;
        end
        viol += int'(q.odt && !dram.odt && n - t_odt < hold);
        viol += int'(dqs_oe && !oe_q && n - t_mrs < LVL_DRIVE_CK);
        viol += int'(dqs_out && !dqs_q && n - t_mrs < LVL_RISE_CK);
        q = dram;
        oe_q = dqs_oe;
        dqs_q = dqs_out;
    end
endmodule : dpt_dram_model

`default_nettype wire

//--- tb/ddr3_pd_odt_level_refresh_timing_tb_top.sv
`default_nettype none

module ddr3_pd_odt_level_refresh_timing_tb_top import dpt_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [4:0] WL = 5'h05;
    localparam logic [4:0] WRP = 5'h06;

    logic      clk = 1'b0, rstn = 1'b0, ce = 1'b1, req_valid = 1'b0, req_chop_otf = 1'b0;
    logic      odt_req = 1'b0, level_pulse = 1'b0, ext_temp = 1'b0, chop4_fixed_setting = 1'b0;
    logic      lock_en = 1'b0, lvl_resp = 1'b0;
    logic      req_ack, refresh_busy, level_seen, dram_ck, dqs_out, dqs_oe, dll_locked, dq_level;
    dpt_req_t  req_cmd = RQ_NOP;
    dpt_dram_t dram;
    int        viol, fails = 0, n_compared = 0;

    always #12.5 clk = ~clk;

    ////////////////////////////////////////
    dpt_host_ctrl i_dpt_host_ctrl (
        .clk(clk), .rstn(rstn), .ce(ce), .req_valid(req_valid), .req_cmd(req_cmd),
        .req_chop_otf(req_chop_otf), .odt_req(odt_req), .level_pulse(level_pulse),
        .ext_temp(ext_temp), .write_latency_clocks(WL), .wr_prog(WRP),
        .chop4_fixed_setting(chop4_fixed_setting), .req_ack(req_ack),
        .refresh_busy(refresh_busy), .level_seen(level_seen), .dram_ck(dram_ck),
        .dram(dram), .dqs_out(dqs_out), .dqs_oe(dqs_oe), .dll_locked(dll_locked),
        .dq_level(dq_level));

    dpt_dram_model i_dpt_dram_model (
        .dram_ck(dram_ck), .dram(dram), .dqs_out(dqs_out), .dqs_oe(dqs_oe), .wl(WL),
        .wr(WRP), .chop(chop4_fixed_setting), .ext(ext_temp), .lock_en(lock_en),
        .lvl_resp(lvl_resp), .dll_locked(dll_locked), .dq_level(dq_level), .viol(viol));

    ////////////////////////////////////////
    task automatic tally_and_finish();
        $display("compared %0d mismatched %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // n counts edges from the raise to the edge that sees the ack
    task automatic req(input dpt_req_t c, input logic otf, output int n);
        n = 1;
        @(posedge clk);
        req_cmd <= c;
        req_chop_otf <= otf;
        req_valid <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (req_ack !== 1'b1 && n < 3000);
        req_valid <= 1'b0;
        if (n >= 3000) begin
            fails++;
            tally_and_finish();
        end
    endtask : req

    task automatic t_lock();
        int   n;
        logic seen;
        req(RQ_PDE, 1'b0, n);
        req(RQ_PDX, 1'b0, n);
        chk(dram.cke, 1'b1);
        @(posedge clk);
        req_cmd <= RQ_RD;
        req_valid <= 1'b1;
        seen = 1'b0;
        repeat (60) begin
            @(posedge clk);
            seen |= req_ack;
        end
        chk(seen, 1'b0);
        lock_en <= 1'b1;
        req_valid <= 1'b0;
        req(RQ_RD, 1'b0, n);
        chk(dram.cmd, CMD_RD);
        $display("done: lock");
    endtask : t_lock

    // every trigger in turn, then the earliest power-down
    task automatic t_gaps();
        dpt_req_t cs[7] = '{RQ_WR, RQ_WR, RQ_WRA, RQ_WRA, RQ_REF, RQ_MRS, RQ_WR};
        int       e, n;
        for (int k = 0; k < 7; k++) begin
            chop4_fixed_setting <= k inside {1, 3};
            e = WL + (k inside {1, 3} ? CHOP4_BASE_CK : BURST8_BASE_CK);
            e = k < 2 || k == 6 ? e + WR_ROUND_CK : k < 4 ? e + WRP + 1 : k == 4 ? REFPD_CK : MOD_CK;
            req(cs[k], k == 6, n);
            req(RQ_PDE, 1'b0, n);
            chk(n >= 2 * e && n <= 2 * e + 16, 1'b1);
            req(RQ_PDX, 1'b0, n);
        end
        $display("done: gaps");
    endtask : t_gaps

    // one missed cycle at the rise is allowed, two when a write cuts in
    task automatic t_term(input logic long_wr);
        int n, hi;
        @(posedge clk);
        chop4_fixed_setting <= 1'b0;
        odt_req <= 1'b1;
        hi = 0;
        if (long_wr)
            req(RQ_WR, 1'b0, n);
        else
            repeat (2) @(posedge clk);
        odt_req <= 1'b0;
        repeat (40) begin
            @(posedge clk);
            hi += int'(dram.odt === 1'b1);
        end
        chk(hi >= 2 * (long_wr ? TERM_LONG_CK : TERM_SHORT_CK) - 1 - long_wr, 1'b1);
        chk(dram.odt, 1'b0);
        $display("done: termination");
    endtask : t_term

    task automatic t_level();
        int n, oe_at, rise_at;
        req(RQ_LVL, 1'b0, n);
        lvl_resp <= 1'b1;
        level_pulse <= 1'b1;
        @(posedge clk);
        level_pulse <= 1'b0;
        oe_at = 0;
        rise_at = 0;
        for (int c = 3; c < 200 && rise_at == 0; c++) begin
            @(posedge clk);
            if (dqs_oe === 1'b1 && oe_at == 0)
                oe_at = c;
            if (dqs_out === 1'b1)
                rise_at = c;
        end
        chk(oe_at >= 2 * LVL_DRIVE_CK && oe_at <= 2 * LVL_DRIVE_CK + 8, 1'b1);
        chk(rise_at >= 2 * LVL_RISE_CK && rise_at <= 2 * LVL_RISE_CK + 8, 1'b1);
        repeat (12) @(posedge clk);
        chk(level_seen, 1'b1);
        lvl_resp <= 1'b0;
        level_pulse <= 1'b1;
        @(posedge clk);
        level_pulse <= 1'b0;
        repeat (16) @(posedge clk);
        chk(level_seen, 1'b0);
        req(RQ_LVX, 1'b0, n);
        $display("done: leveling");
    endtask : t_level

    // refreshes counted over a fixed window at either temperature
    task automatic t_refresh(input logic ext);
        int       cnt, e;
        dpt_cmd_t prev;
        @(posedge clk);
        ext_temp <= ext;
        repeat (400) @(posedge clk);
        cnt = 0;
        prev = CMD_NOP;
        e = 3 * REFI_NORM_CYC / (ext ? REFI_EXT_CYC : REFI_NORM_CYC);
        repeat (3 * REFI_NORM_CYC) begin
            @(posedge clk);
            cnt += int'(dram.cmd === CMD_REF && prev !== CMD_REF);
            prev = dram.cmd;
        end
        chk(cnt >= e - 1 && cnt <= e + 1, 1'b1);
        $display("done: refresh");
    endtask : t_refresh

    ////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clk);
        chk(dram, DRAM_RESET);
        chk(dqs_oe, 1'b0);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        chk(refresh_busy, 1'b1);
        t_lock();
        t_gaps();
        t_term(1'b0);
        t_term(1'b1);
        t_level();
        t_refresh(1'b0);
        t_refresh(1'b1);
        chk(viol, 0);
        tally_and_finish();
    end
endmodule : ddr3_pd_odt_level_refresh_timing_tb_top

`default_nettype wire
